// ---- design/lpbc_fifo.sv ----
// code group fifo with valid and ready on both sides
module lpbc_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // fill side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // drain side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign o_in_ready = (cnt_q != FULL);
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data = mem_q[rd_ptr_q];
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;

  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= i_in_data;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == LAST) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == LAST) ? '0 : rd_ptr_q + 1'b1;
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_q <= '0;
    end else if (push & ~pop) begin
      cnt_q <= cnt_q + 1'b1;
    end else if (pop & ~push) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

endmodule : lpbc_fifo

// ---- design/lpbc_params.svh ----
// offsets, field positions, reset values and codes of the lane test block
`ifndef LPBC_PARAMS_SVH
`define LPBC_PARAMS_SVH

// ----------------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------------
`define LPBC_ADDR_W 20
`define LPBC_ADDR_CNT_HI 20'h130e4
`define LPBC_ADDR_CNT_LO 20'h130e8
`define LPBC_ADDR_PATTERN 20'h130ec
`define LPBC_ADDR_CTRL 20'h130f8

// ----------------------------------------------------------------------
// widths and reset values
// ----------------------------------------------------------------------
`define LPBC_CG_W 48
`define LPBC_ERR_W 16
`define LPBC_ZERO_WORD 32'h00000000
`define LPBC_PAT_RESET 32'h00000000
`define LPBC_PAT_MASK 32'h03ff03ff
`define LPBC_CG_RESET 48'h000000000000
`define LPBC_ERR_RESET 16'h0000
`define LPBC_ERR_MAX 16'hffff

// ----------------------------------------------------------------------
// fields (bus bit = 31 - register bit)
// ----------------------------------------------------------------------
`define LPBC_FIRST_MSB 9
`define LPBC_FIRST_LSB 0
`define LPBC_SECOND_MSB 25
`define LPBC_SECOND_LSB 16
`define LPBC_HI_CG_MSB 31
`define LPBC_HI_CG_LSB 16
`define LPBC_CG_SPLIT 32
`define LPBC_CTRL_ENABLE 0
`define LPBC_SEL_MSB 3
`define LPBC_SEL_LSB 1
`define LPBC_CTRL_CLEAR 4
`define LPBC_CTRL_FREEZE 5
`define LPBC_SEL_FIXED 3'h4

`endif

// ---- design/lpbc_pkg.sv ----
// types shared by the lane test block
package lpbc_pkg;

  // ----------------------------------------------------------------------
  // control fields held by software
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic freeze_lane3_counting;
    logic [2:0] pattern_select;
    logic bert_enable;
  } lpbc_ctrl_type;

  // ----------------------------------------------------------------------
  // one register access as seen at the access edge
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [19:0] addr;
    logic [31:0] wdata;
  } lpbc_req_type;

  typedef enum logic [1:0] {
    LPBC_GEN_IDLE = 2'b00,
    LPBC_GEN_FIRST = 2'b01,
    LPBC_GEN_SECOND = 2'b10
  } lpbc_gen_state_type;

endpackage : lpbc_pkg

// ---- design/lpbc_top.sv ----
// lane test counters, fixed pattern source and apb register file
//
// Behaviour
// - 48-bit code group count, top 16 bits in first counter word.
// - low 32 bits of code group count fill the second word.
// - 16-bit mismatch count sits in the first word's low half.
// - zero write to a word zeroes the counter bits in that word; shared clear zeroes both counters.
// - both counters together give software the error rate operands.
// - the first fixed word goes out first, its top bit leading.
// - the second fixed word follows, its top bit leading.
// - both words go out as ready-made code groups, not re-encoded.
// - the two-word sequence repeats until the test is disabled.
// - reserved pattern bits read zero; both words reset to zero.
//
// Chosen here: the APB interface to the registers.
`include "lpbc_params.svh"

module lpbc_top import lpbc_pkg::*; #(
  parameter int GROUP_W = 10,
  parameter int FIFO_DEPTH = 16
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [19:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  // lane 3 checker results
  input wire logic i_rx_group_valid,
  input wire logic i_rx_group_mismatch,
  // lane 0 transmit code groups
  output logic o_tx_valid,
  output logic [GROUP_W-1:0] o_tx_group,
  input wire logic i_tx_ready,
  // status
  output logic o_fixed_active
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  lpbc_ctrl_type ctrl_q;
  lpbc_req_type req;
  lpbc_gen_state_type gen_q;
  logic [31:0] pattern_q;
  logic [`LPBC_CG_W-1:0] cg_q;
  logic [`LPBC_CG_W-1:0] cg_sum;
  logic [`LPBC_CG_W-1:0] cg_d;
  logic [`LPBC_ERR_W-1:0] err_q;
  logic [`LPBC_ERR_W-1:0] err_d;
  logic [15:0] cg_hi;
  logic [31:0] cg_lo;
  logic pready_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic setup;
  logic hit_hi;
  logic hit_lo;
  logic hit_pat;
  logic hit_ctrl;
  logic [31:0] rd_word;
  logic rd_hit;
  logic clr_shared;
  logic clr_hi;
  logic clr_lo;
  logic count_en;
  logic err_en;
  logic fixed_sel;
  logic [GROUP_W-1:0] first_word;
  logic [GROUP_W-1:0] second_word;
  logic gen_valid;
  logic [GROUP_W-1:0] gen_data;
  logic gen_push;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [GROUP_W-1:0] fifo_out_data;
  logic fifo_pop;
  logic tx_valid_q;
  logic [GROUP_W-1:0] tx_group_q;
  logic fixed_active_q;

  // ----------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------
  assign setup = i_psel & ~i_penable;
  assign req.wr = i_psel & i_penable & pready_q & i_pwrite;
  assign req.rd = i_psel & i_penable & pready_q & ~i_pwrite;
  assign req.addr = i_paddr;
  assign req.wdata = i_pwdata;
  assign hit_hi = (req.addr == `LPBC_ADDR_CNT_HI);
  assign hit_lo = (req.addr == `LPBC_ADDR_CNT_LO);
  assign hit_pat = (req.addr == `LPBC_ADDR_PATTERN);
  assign hit_ctrl = (req.addr == `LPBC_ADDR_CTRL);

  assign cg_hi = cg_q[`LPBC_CG_W-1:`LPBC_CG_SPLIT];
  assign cg_lo = cg_q[`LPBC_CG_SPLIT-1:0];

  // ----------------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------------
  // msb-0 numbering: register bits 0:15 land on bus bits 31:16
  always_comb begin
    rd_word = `LPBC_ZERO_WORD;
    rd_hit = 1'b1;
    case (1'b1)
      hit_hi: begin
        rd_word = {cg_hi, err_q};
      end
      hit_lo: begin
        rd_word = cg_lo;
      end
      hit_pat: begin
        rd_word = pattern_q & `LPBC_PAT_MASK;
      end
      hit_ctrl: begin
        rd_word[`LPBC_CTRL_ENABLE] = ctrl_q.bert_enable;
        rd_word[`LPBC_SEL_MSB:`LPBC_SEL_LSB] = ctrl_q.pattern_select;
        rd_word[`LPBC_CTRL_FREEZE] = ctrl_q.freeze_lane3_counting;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // apb answer: one wait-free access phase after every setup
  // ----------------------------------------------------------------------
  // read data is caught at setup; software freezes counting first so
  // the two counter words belong to the same instant
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pready_q <= 1'b0;
      prdata_q <= `LPBC_ZERO_WORD;
      pslverr_q <= 1'b0;
    end else if (setup & ~pready_q) begin
      pready_q <= 1'b1;
      prdata_q <= i_pwrite ? `LPBC_ZERO_WORD : rd_word;
      pslverr_q <= ~rd_hit;
    end else begin
      pready_q <= 1'b0;
      prdata_q <= `LPBC_ZERO_WORD;
      pslverr_q <= 1'b0;
    end
  end

  assign o_pready = pready_q;
  assign o_prdata = prdata_q;
  assign o_pslverr = pslverr_q;

  // ----------------------------------------------------------------------
  // pattern and control registers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pattern_q <= `LPBC_PAT_RESET;
    end else if (req.wr & hit_pat) begin
      pattern_q <= req.wdata & `LPBC_PAT_MASK;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ctrl_q <= '0;
    end else if (req.wr & hit_ctrl) begin
      ctrl_q.bert_enable <= req.wdata[`LPBC_CTRL_ENABLE];
      ctrl_q.pattern_select <= req.wdata[`LPBC_SEL_MSB:`LPBC_SEL_LSB];
      ctrl_q.freeze_lane3_counting <= req.wdata[`LPBC_CTRL_FREEZE];
    end
  end

  // ----------------------------------------------------------------------
  // lane 3 counters
  // ----------------------------------------------------------------------
  assign clr_shared = req.wr & hit_ctrl & req.wdata[`LPBC_CTRL_CLEAR];
  assign clr_hi = req.wr & hit_hi & (req.wdata == `LPBC_ZERO_WORD);
  assign clr_lo = req.wr & hit_lo & (req.wdata == `LPBC_ZERO_WORD);
  assign count_en = i_rx_group_valid & ~ctrl_q.freeze_lane3_counting;
  assign err_en = count_en & i_rx_group_mismatch;

  // a group arriving with a clear is counted after the clear
  always_comb begin
    cg_sum = cg_q + `LPBC_CG_W'(count_en);
    cg_d = cg_sum;
    if (clr_shared) begin
      cg_d = `LPBC_CG_W'(count_en);
    end else begin
      if (clr_hi) begin
        cg_d[`LPBC_CG_W-1:`LPBC_CG_SPLIT] = '0;
      end
      // the low clear must not carry into the untouched high part
      if (clr_lo) begin
        cg_d = {cg_q[`LPBC_CG_W-1:`LPBC_CG_SPLIT],
                32'(count_en)};
      end
    end
  end

  // the error count sticks at its top value rather than wrapping,
  // so a long run never reports a falsely low rate
  always_comb begin
    err_d = err_q;
    if (clr_shared | clr_hi) begin
      err_d = `LPBC_ERR_W'(err_en);
    end else if (err_en & (err_q != `LPBC_ERR_MAX)) begin
      err_d = err_q + 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cg_q <= `LPBC_CG_RESET;
      err_q <= `LPBC_ERR_RESET;
    end else begin
      cg_q <= cg_d;
      err_q <= err_d;
    end
  end

  // ----------------------------------------------------------------------
  // lane 0 fixed pattern source
  // ----------------------------------------------------------------------
  assign fixed_sel = ctrl_q.bert_enable &
                     (ctrl_q.pattern_select == `LPBC_SEL_FIXED);
  assign first_word = pattern_q[`LPBC_FIRST_MSB:`LPBC_FIRST_LSB];
  assign second_word = pattern_q[`LPBC_SECOND_MSB:`LPBC_SECOND_LSB];
  assign gen_valid = (gen_q != LPBC_GEN_IDLE) & fixed_sel;
  assign gen_push = gen_valid & fifo_in_ready;

  // words go out raw; bit 9 of a group is the first on the wire
  always_comb begin
    case (gen_q)
      LPBC_GEN_FIRST: begin
        gen_data = first_word;
      end
      LPBC_GEN_SECOND: begin
        gen_data = second_word;
      end
      default: begin
        gen_data = first_word;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      gen_q <= LPBC_GEN_IDLE;
    end else if (!fixed_sel) begin
      gen_q <= LPBC_GEN_IDLE;
    end else begin
      case (gen_q)
        LPBC_GEN_IDLE: begin
          gen_q <= LPBC_GEN_FIRST;
        end
        LPBC_GEN_FIRST: begin
          if (gen_push) begin
            gen_q <= LPBC_GEN_SECOND;
          end
        end
        LPBC_GEN_SECOND: begin
          if (gen_push) begin
            gen_q <= LPBC_GEN_FIRST;
          end
        end
        default: begin
          gen_q <= LPBC_GEN_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // buffer and transmit stage
  // ----------------------------------------------------------------------
  // groups already queued still drain after disable; the lane never
  // sees a word cut in half
  lpbc_fifo #(
    .WIDTH(GROUP_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_in_valid(gen_valid),
    .i_in_data(gen_data),
    .o_in_ready(fifo_in_ready),
    .o_out_valid(fifo_out_valid),
    .o_out_data(fifo_out_data),
    .i_out_ready(fifo_pop)
  );

  assign fifo_pop = ~tx_valid_q | i_tx_ready;

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tx_valid_q <= 1'b0;
      tx_group_q <= '0;
    end else if (fifo_pop) begin
      tx_valid_q <= fifo_out_valid;
      if (fifo_out_valid) begin
        tx_group_q <= fifo_out_data;
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      fixed_active_q <= 1'b0;
    end else begin
      fixed_active_q <= fixed_sel;
    end
  end

  assign o_tx_valid = tx_valid_q;
  assign o_tx_group = tx_group_q;
  assign o_fixed_active = fixed_active_q;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);

  group_count_a: assert property (
    count_en & ~clr_shared & ~clr_hi & ~clr_lo |=> cg_q == $past(cg_q) + 1)
    else $error("code group count did not step");

  error_count_a: assert property (
    err_en & ~clr_shared & ~clr_hi & (err_q != `LPBC_ERR_MAX)
    |=> err_q == $past(err_q) + 1)
    else $error("mismatch count did not step");

  freeze_hold_a: assert property (
    ctrl_q.freeze_lane3_counting & ~clr_shared & ~clr_hi & ~clr_lo
    |=> $stable(cg_q) && $stable(err_q))
    else $error("counters moved while frozen");

  shared_clear_a: assert property (
    clr_shared & ~i_rx_group_valid |=> cg_q == '0 && err_q == '0)
    else $error("shared clear left a count");

  high_read_a: assert property (
    setup & ~pready_q & ~i_pwrite & hit_hi
    |=> o_pready && o_prdata == {$past(cg_hi), $past(err_q)})
    else $error("first counter word wrong");

  low_read_a: assert property (
    setup & ~pready_q & ~i_pwrite & hit_lo
    |=> o_pready && o_prdata == $past(cg_lo))
    else $error("second counter word wrong");

  reserved_zero_a: assert property (
    (pattern_q & ~`LPBC_PAT_MASK) == `LPBC_ZERO_WORD)
    else $error("reserved pattern bits set");

  word_order_a: assert property (
    gen_push & (gen_q == LPBC_GEN_FIRST)
    |-> gen_data == first_word ##1 gen_q == LPBC_GEN_SECOND)
    else $error("first word not sent first");

  repeat_seq_a: assert property (
    gen_push & (gen_q == LPBC_GEN_SECOND) & fixed_sel
    |=> gen_q == LPBC_GEN_FIRST || !fixed_sel)
    else $error("pattern did not repeat");

  start_fixed_a: assert property (
    (gen_q == LPBC_GEN_IDLE) & fixed_sel |=> gen_q == LPBC_GEN_FIRST)
    else $error("fixed pattern did not start");

  clear_cover_c: cover property (clr_shared ##1 count_en);
  send_cover_c: cover property (o_tx_valid & i_tx_ready ##1
    o_tx_valid & i_tx_ready);
  full_cover_c: cover property (gen_valid & ~fifo_in_ready);
  read_cover_c: cover property (req.rd & hit_hi);

endmodule : lpbc_top

// ---- dv/lpbc_lane_model.sv ----
// lane partner model: lane 3 checker results and lane 0 receiver
module lpbc_lane_model (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  // bench controls
  input wire logic i_rx_on,
  input wire logic i_stall_on,
  // toward the block
  output logic o_rx_group_valid,
  output logic o_rx_group_mismatch,
  output logic o_tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------------
  // lane 3 checker: one compared group per valid cycle
  // ----------------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rx_group_valid <= 1'b0;
      o_rx_group_mismatch <= 1'b0;
    end else begin
      o_rx_group_valid <= i_rx_on & ($urandom_range(0, 3) != 0);
      // churns while valid is low, so a design reading it then is caught
      o_rx_group_mismatch <= ($urandom_range(0, 2) == 0);
    end
  end

  // ----------------------------------------------------------------------
  // lane 0 receiver: random stalls back the queue up
  // ----------------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_tx_ready <= 1'b0;
    end else begin
      o_tx_ready <= i_stall_on ? ($urandom_range(0, 2) == 0) : 1'b1;
    end
  end
endmodule : lpbc_lane_model

// ---- dv/lpbc_top_tb.sv ----
// self-checking bench for the lane test counters and fixed pattern
`include "lpbc_params.svh"
module lpbc_top_tb import lpbc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------------
  // signals and reference state
  // ----------------------------------------------------------------------
  logic i_ref_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [19:0] paddr = 20'h00000;
  logic [31:0] pwdata = 32'h00000000;
  logic pready, pslverr, rx_v, rx_m, tx_v, tx_rdy, fix_act;
  logic [31:0] prdata;
  logic [9:0] tx_g;
  logic rx_on = 1'b0;
  logic stall_on = 1'b0;
  logic frz_m = 1'b0;
  logic [47:0] exp_cg = 48'h000000000000;
  logic [15:0] exp_err = 16'h0000;
  logic [31:0] pat = 32'h00000000;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;
  int n_tx = 0;

  always #4 i_ref_clk = ~i_ref_clk;

  lpbc_top dut (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
    .o_pslverr(pslverr), .i_rx_group_valid(rx_v),
    .i_rx_group_mismatch(rx_m), .o_tx_valid(tx_v), .o_tx_group(tx_g),
    .i_tx_ready(tx_rdy), .o_fixed_active(fix_act));

  lpbc_lane_model lane (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
    .i_rx_on(rx_on), .i_stall_on(stall_on), .o_rx_group_valid(rx_v),
    .o_rx_group_mismatch(rx_m), .o_tx_ready(tx_rdy));

  // ----------------------------------------------------------------------
  // compare and report
  // ----------------------------------------------------------------------
  task automatic chk_word(input string nm, input logic [31:0] e,
                          input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word

  task automatic chk_bit(input string nm, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit

  task automatic print_verdict();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------------------
  // reference models: counters and transmitted groups
  // ----------------------------------------------------------------------
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      print_verdict();
    end
    if (!i_sys_rst && rx_v === 1'b1 && !frz_m) begin
      exp_cg = exp_cg + 48'h1;
      if (rx_m === 1'b1 && exp_err != 16'hffff) begin
        exp_err = exp_err + 16'h1;
      end
    end
    if (!i_sys_rst && tx_v === 1'b1 && tx_rdy) begin
      chk_word("tx group", {22'h0, n_tx[0] ? pat[25:16] : pat[9:0]},
               {22'h0, tx_g});
      n_tx++;
    end
  end

  // ----------------------------------------------------------------------
  // apb master and helpers
  // ----------------------------------------------------------------------
  task automatic apb(input logic wr, input logic [19:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    @(posedge i_ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge i_ref_clk);
    penable <= 1'b1;
    // no wait count assumed: only the bench's cycle ceiling ends this
    do begin
      @(posedge i_ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [19:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd_chk(input string nm, input logic [19:0] a,
                        input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h00000000, r, e);
    chk_word(nm, exp, r);
  endtask : rd_chk

  function automatic logic [31:0] ctl(input logic en, input logic [2:0] sel,
                                     input logic clr, input logic frz);
    return {26'h0, frz, clr, sel, en};
  endfunction : ctl

  // rx stops a few cycles before any control change, so no group races it
  task automatic run_rx(input int n);
    rx_on <= 1'b1;
    repeat (n) @(posedge i_ref_clk);
    rx_on <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
  endtask : run_rx

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic e;
    int k;
    void'($urandom(92));
    repeat (10) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    rd_chk("count high", `LPBC_ADDR_CNT_HI, 32'h0);
    rd_chk("count low", `LPBC_ADDR_CNT_LO, 32'h0);
    rd_chk("pattern", `LPBC_ADDR_PATTERN, 32'h0);
    wr(`LPBC_ADDR_PATTERN, 32'hffffffff);
    rd_chk("pattern", `LPBC_ADDR_PATTERN, 32'h03ff03ff);
    apb(1'b0, 20'h130f0, 32'h00000000, r, e);
    chk_bit("unmapped error", 1'b1, e);
    chk_word("unmapped data", 32'h0, r);
    for (k = 0; k < 3; k++) begin
      run_rx(50 + $urandom_range(0, 150));
      wr(`LPBC_ADDR_CTRL, ctl(1'b0, 3'h0, 1'b0, 1'b1));
      frz_m = 1'b1;
      run_rx(40);
      rd_chk("count high", `LPBC_ADDR_CNT_HI,
             {exp_cg[47:32], exp_err});
      rd_chk("count low", `LPBC_ADDR_CNT_LO,
             exp_cg[31:0]);
      wr(`LPBC_ADDR_CTRL, ctl(1'b0, 3'h0, 1'b0, 1'b0));
      frz_m = 1'b0;
    end
    wr(`LPBC_ADDR_CNT_LO, 32'h00000001);
    wr(`LPBC_ADDR_CNT_HI, 32'h00000000);
    exp_cg[47:32] = 16'h0000;
    exp_err = 16'h0000;
    rd_chk("count high", `LPBC_ADDR_CNT_HI, 32'h0);
    rd_chk("count low", `LPBC_ADDR_CNT_LO, exp_cg[31:0]);
    wr(`LPBC_ADDR_CNT_LO, 32'h00000000);
    exp_cg[31:0] = 32'h00000000;
    rd_chk("count low", `LPBC_ADDR_CNT_LO, 32'h0);
    run_rx(80);
    wr(`LPBC_ADDR_CTRL, ctl(1'b0, 3'h0, 1'b1, 1'b0));
    exp_cg = 48'h0;
    exp_err = 16'h0000;
    rd_chk("count high", `LPBC_ADDR_CNT_HI, 32'h0);
    rd_chk("count low", `LPBC_ADDR_CNT_LO, 32'h0);
    for (k = 0; k < 8; k++) begin
      if (k == 4) continue;
      wr(`LPBC_ADDR_CTRL, ctl(1'b1, k[2:0], 1'b0, 1'b0));
      repeat (30) @(posedge i_ref_clk);
      chk_word("groups out", 32'h0, n_tx);
      chk_bit("fixed active", 1'b0, fix_act);
    end
    wr(`LPBC_ADDR_CTRL, 32'h0);
    r = $urandom();
    wr(`LPBC_ADDR_PATTERN, r);
    pat = r & `LPBC_PAT_MASK;
    rd_chk("pattern", `LPBC_ADDR_PATTERN, pat);
    stall_on <= 1'b1;
    wr(`LPBC_ADDR_CTRL, ctl(1'b1, 3'h4, 1'b0, 1'b0));
    repeat (3) @(posedge i_ref_clk);
    chk_bit("fixed active", 1'b1, fix_act);
    repeat (300) @(posedge i_ref_clk);
    wr(`LPBC_ADDR_CTRL, 32'h0);
    stall_on <= 1'b0;
    repeat (40) @(posedge i_ref_clk);
    k = n_tx;
    chk_bit("many groups", 1'b1, n_tx > 40);
    repeat (20) @(posedge i_ref_clk);
    chk_word("groups after stop", k, n_tx);
    chk_bit("tx idle", 1'b0, tx_v);
    print_verdict();
  end
endmodule : lpbc_top_tb
